// file: pkg/cap_stage_result_consts.svh
// offsets, field positions, reset values and bus codes of the stage 8..15 result registers
// assumes inclusion by the package, the register block, the checker and the testbench
`ifndef CAP_STAGE_RESULT_CONSTS_SVH
`define CAP_STAGE_RESULT_CONSTS_SVH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define STAGE8_9_RESULT_ADDR 32'h4008_40BC
`define STAGE10_11_RESULT_ADDR 32'h4008_40C0
`define STAGE12_13_RESULT_ADDR 32'h4008_40C4
`define STAGE14_15_RESULT_ADDR 32'h4008_40C8
`define RESULT_CTRL_ADDR 32'h4008_4200

// ***************************************************************
// field layout
// ***************************************************************
`define STAGE_VALUE_WIDTH 14
`define STAGE_COUNT 8
`define FIRST_STAGE 8
`define ODD_SIGN_BIT 31
`define ODD_VALUE_LSB 16
`define EVEN_SIGN_BIT 15
`define EVEN_VALUE_LSB 0
`define RESULT_SELECT_BIT 0

// ***************************************************************
// reset values and answers
// ***************************************************************
`define RESULT_RESET 32'h0000_0000
`define STAGE_VALUE_RESET 14'h0000
`define RESP_OKAY 2'h0
`define RESP_DECODEERROR 2'h3

`endif

// file: pkg/cap_stage_result_pkg.sv
// types shared by the stage 8..15 result register block
// assumes cap_stage_result_consts.svh is on the include path
`include "cap_stage_result_consts.svh"

package cap_stage_result_pkg;

   // one 16-bit half of a result register
   typedef struct packed {
      logic deltaNegative;
      logic reservedZero;
      logic [`STAGE_VALUE_WIDTH-1:0] value;
   } stage_field_t;

   // one packed result register, odd stage on top
   typedef struct packed {
      stage_field_t oddStage;
      stage_field_t evenStage;
   } result_word_t;

   // what a stage field shows
   typedef enum logic {
      SHOW_RAW,
      SHOW_DELTA
   } result_mode_t;

   // avalon slave bus phases
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

endpackage

// file: verilog/cap_stage_result_regs.sv
// read-only result registers for touch sensing stages 8 to 15, on an avalon-mm slave with waitrequest
// assumes conversion results and baselines arrive from logic on clk_sys; the conversion strobe is one cycle
//
// Contract
// [RULE1] with result select 0 each field shows its stage's raw conversion result, odd stage in 29:16, even in 13:0.
// [RULE2] with result select 1 each field shows the absolute difference between result and that stage's baseline.
// [RULE3] in difference mode bits 31 and 15 read 0 when the result is above the baseline and 1 when below.
// [RULE4] the register at 0x400840BC shows stage 9 in the upper half and stage 8 in the lower half.
// [RULE5] the register at 0x400840C0 shows stage 11 in the upper half and stage 10 in the lower half.
// [RULE6] the register at 0x400840C4 shows stage 13 in the upper half and stage 12 in the lower half.
// [RULE7] the register at 0x400840C8 shows stage 15 in the upper half and stage 14 in the lower half.
// [RULE8] the baseline subtracted is the stage's own 14-bit baseline value held by the device.
// [RULE9] bits 30 and 14 always read zero and writes leave the result registers unchanged.
//
// Chosen here: the Avalon-MM register port.
`include "cap_stage_result_consts.svh"

module cap_stage_result_regs
   import cap_stage_result_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [31:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   // conversion side, stage 8 at index 0
   input wire logic convDone,
   input wire logic [`STAGE_COUNT-1:0][`STAGE_VALUE_WIDTH-1:0] convResult,
   input wire logic [`STAGE_COUNT-1:0][`STAGE_VALUE_WIDTH-1:0] stageBaseline,
   // control state seen by the sensing logic
   output logic result_select
);

   // ***************************************************************
   // state
   // ***************************************************************
   logic [`STAGE_COUNT-1:0][`STAGE_VALUE_WIDTH-1:0] stageValue_reg;
   result_mode_t resultMode_reg;
   bus_state_t busState_reg;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [1:0] response_reg;
   logic [31:0] readdata_next;
   logic [1:0] response_next;
   logic mapped;

   // ***************************************************************
   // field formatting
   // ***************************************************************
   // shared by all eight fields; a tie reads as magnitude 0 with sign 0
   function automatic stage_field_t format_field(
      input result_mode_t mode,
      input logic [`STAGE_VALUE_WIDTH-1:0] result,
      input logic [`STAGE_VALUE_WIDTH-1:0] baseline
   );
      stage_field_t f;
      f = '0;
      if (mode == SHOW_RAW) begin
         f.value = result; // RULE1
      end else if (result < baseline) begin
         f.value = baseline - result; // RULE2
         f.deltaNegative = 1'b1; // RULE3
      end else begin
         f.value = result - baseline; // RULE2
         f.deltaNegative = 1'b0; // RULE3
      end
      f.reservedZero = 1'b0; // RULE9
      return f;
   endfunction

   function automatic result_word_t pair_word(
      input result_mode_t mode,
      input logic [`STAGE_VALUE_WIDTH-1:0] oddResult,
      input logic [`STAGE_VALUE_WIDTH-1:0] oddBaseline,
      input logic [`STAGE_VALUE_WIDTH-1:0] evenResult,
      input logic [`STAGE_VALUE_WIDTH-1:0] evenBaseline
   );
      result_word_t w;
      w.oddStage = format_field(mode, oddResult, oddBaseline);
      w.evenStage = format_field(mode, evenResult, evenBaseline);
      return w;
   endfunction

   // ***************************************************************
   // conversion capture
   // ***************************************************************
   // results hold between conversions so a read mid-sequence sees a whole sample
   genvar s;
   generate
      for (s = 0; s < `STAGE_COUNT; s++) begin : gStage
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               stageValue_reg[s] <= `STAGE_VALUE_RESET;
            end else if (convDone) begin
               stageValue_reg[s] <= convResult[s];
            end
         end
      end
   endgenerate

   // ***************************************************************
   // read decode
   // ***************************************************************
   // baselines are read live so a baseline update shows on the next read
   always_comb begin
      readdata_next = `RESULT_RESET;
      mapped = 1'b1;
      if (address == `STAGE8_9_RESULT_ADDR) begin
         readdata_next = pair_word(resultMode_reg, stageValue_reg[1], stageBaseline[1],
                                   stageValue_reg[0], stageBaseline[0]); // RULE4 RULE8
      end else if (address == `STAGE10_11_RESULT_ADDR) begin
         readdata_next = pair_word(resultMode_reg, stageValue_reg[3], stageBaseline[3],
                                   stageValue_reg[2], stageBaseline[2]); // RULE5 RULE8
      end else if (address == `STAGE12_13_RESULT_ADDR) begin
         readdata_next = pair_word(resultMode_reg, stageValue_reg[5], stageBaseline[5],
                                   stageValue_reg[4], stageBaseline[4]); // RULE6 RULE8
      end else if (address == `STAGE14_15_RESULT_ADDR) begin
         readdata_next = pair_word(resultMode_reg, stageValue_reg[7], stageBaseline[7],
                                   stageValue_reg[6], stageBaseline[6]); // RULE7 RULE8
      end else if (address == `RESULT_CTRL_ADDR) begin
         readdata_next[`RESULT_SELECT_BIT] = (resultMode_reg == SHOW_DELTA);
      end else begin
         mapped = 1'b0;
      end
      response_next = mapped ? `RESP_OKAY : `RESP_DECODEERROR;
   end

   // ***************************************************************
   // bus handshake
   // ***************************************************************
   // one wait cycle keeps readdata and waitrequest straight off flip-flops
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busState_reg <= BUS_IDLE;
      end else begin
         case (busState_reg)
            BUS_IDLE: begin
               if (read || write) begin
                  busState_reg <= BUS_ACK;
               end
            end
            BUS_ACK: begin
               busState_reg <= BUS_IDLE;
            end
            default: begin
               busState_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   // waitrequest mirrors the next bus state so the pin comes straight off its own flop
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest_reg <= 1'b1;
      end else begin
         waitrequest_reg <= !(busState_reg == BUS_IDLE && (read || write));
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         readdata_reg <= `RESULT_RESET;
         response_reg <= `RESP_OKAY;
      end else if (busState_reg == BUS_IDLE && (read || write)) begin
         readdata_reg <= read ? readdata_next : `RESULT_RESET;
         response_reg <= response_next;
      end
   end

   // ***************************************************************
   // control register
   // ***************************************************************
   // only the control word is writable; result addresses ignore writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         resultMode_reg <= SHOW_RAW;
      end else if (busState_reg == BUS_ACK && write && address == `RESULT_CTRL_ADDR && byteenable[0]) begin
         resultMode_reg <= writedata[`RESULT_SELECT_BIT] ? SHOW_DELTA : SHOW_RAW; // RULE9
      end
   end

   assign readdata = readdata_reg;
   assign waitrequest = waitrequest_reg;
   assign response = response_reg;
   assign result_select = (resultMode_reg == SHOW_DELTA);

endmodule

// file: dv/cap_stage_result_checker.sv
// bus and field assertions for the stage 8..15 result registers
// assumes it is bound onto cap_stage_result_regs
`include "cap_stage_result_consts.svh"
module cap_stage_result_checker
   import cap_stage_result_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [31:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   input wire logic result_select
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic ack, ctl, hit;
   assign ack = read && !waitrequest;
   assign ctl = address == `RESULT_CTRL_ADDR;
   // unaligned addresses count as unmapped
   assign hit = ctl || (address >= `STAGE8_9_RESULT_ADDR && address <= `STAGE14_15_RESULT_ADDR && address[1:0] == 2'h0);
   a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no ack");
   a_ack_single: assert property (!waitrequest |=> waitrequest) else $error("ack too long");
   a_reserved_zero: assert property (ack |-> !readdata[30] && !readdata[14]) else $error("reserved set");
   a_raw_unsigned: assert property (ack && !result_select |-> !readdata[31] && !readdata[15]) else $error("sign");
   a_unmapped_decode: assert property (ack && !hit |-> response == `RESP_DECODEERROR && readdata == 32'h0000_0000)
      else $error("unmapped answer");
   a_mapped_okay: assert property (!waitrequest && hit |-> response == `RESP_OKAY) else $error("mapped answer");
   a_select_write: assert property (write && !waitrequest && ctl && byteenable[0] |=> result_select == $past(writedata[0]))
      else $error("select not written");
   a_select_hold: assert property (!(write && !waitrequest && ctl) |=> $stable(result_select)) else $error("select moved");
   c_raw_read: cover property (ack && hit && !ctl && !result_select);
   c_delta_neg: cover property (ack && result_select && readdata[15]);
   c_unmapped: cover property (ack && !hit);
endmodule
bind cap_stage_result_regs cap_stage_result_checker cap_stage_result_checker_inst (.clk_sys, .arst_n, .address,
   .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .response, .result_select);

// file: dv/testbench.sv
// self-checking bench for the stage 8..15 result registers
// assumes design, package and checker are compiled first
`include "cap_stage_result_consts.svh"
`define CHK(a, b) checked++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h %h", $time, a, b); end
module testbench
   import cap_stage_result_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, convDone = 1'b0, waitrequest, result_select;
   logic [31:0] address = 32'h0000_0000, writedata = 32'h0000_0000, readdata, q;
   logic [3:0] byteenable = 4'hF;
   logic [1:0] response, r;
   logic [7:0][13:0] convResult = '0, stageBaseline = '0;
   int failures = 0, checked = 0;
   always #12.5 clk_sys = ~clk_sys;
   cap_stage_result_regs cap_stage_result_regs_inst (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .response(response),
      .convDone(convDone),
      .convResult(convResult),
      .stageBaseline(stageBaseline),
      .result_select(result_select)
   );
   function automatic logic [15:0] fld(input logic m, input logic [13:0] v, input logic [13:0] b);
      if (!m) return {2'h0, v};
      return (v < b) ? {2'h2, b - v} : {2'h0, v - b};
   endfunction
   // one edge of gap first, so release and the next request never meet in one step
   // waitrequest is looked at on the falling edge, where it is settled; the watchdog ends a hang
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      @(negedge clk_sys);
      while (waitrequest !== 1'b0) begin
         @(negedge clk_sys);
      end
      @(posedge clk_sys);
      q = readdata;
      r = response;
      read <= 1'b0;
      write <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic chk_regs(input logic m);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, `STAGE8_9_RESULT_ADDR + 32'(4 * i), 32'h0000_0000);
         `CHK(q, {fld(m, convResult[2*i+1], stageBaseline[2*i+1]), fld(m, convResult[2*i], stageBaseline[2*i])})
         `CHK(r, `RESP_OKAY)
      end
   endtask
   task automatic conv(input logic [13:0] seed);
      @(posedge clk_sys);
      for (int k = 0; k < 8; k++)
         convResult[k] <= seed + 14'(k * 16'h0451);
      convDone <= 1'b1;
      @(posedge clk_sys);
      convDone <= 1'b0;
   endtask
   task automatic t_reset();
      chk_regs(1'b0);
      bus(1'b0, `RESULT_CTRL_ADDR, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
   endtask
   // baselines set in raw mode must not leak into the fields
   task automatic t_raw();
      for (int k = 0; k < 8; k++)
         stageBaseline[k] <= 14'(k * 16'h0123);
      conv(14'h3FF0);
      chk_regs(1'b0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `STAGE8_9_RESULT_ADDR + 32'(4 * i), 32'hFFFF_FFFF);
         `CHK(r, `RESP_OKAY)
      end
      chk_regs(1'b0);
   endtask
   // above, equal and below the baseline in turn across the stages
   task automatic t_delta();
      bus(1'b1, `RESULT_CTRL_ADDR, 32'h0000_0001);
      `CHK(result_select, 1'b1)
      for (int k = 0; k < 8; k++)
         stageBaseline[k] <= convResult[k] + 14'((k % 3) * 14'h0100) - 14'h0100;
      chk_regs(1'b1);
      conv(14'h0005);
      chk_regs(1'b1);
      bus(1'b1, `RESULT_CTRL_ADDR, 32'h0000_0000);
      chk_regs(1'b0);
   endtask
   task automatic t_unmapped();
      bus(1'b1, 32'h4008_40CC, 32'h0000_0001);
      bus(1'b0, 32'h4008_40CC, 32'h0000_0000);
      `CHK(r, `RESP_DECODEERROR)
      `CHK(q, 32'h0000_0000)
      `CHK(result_select, 1'b0)
   endtask
   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_raw();
      t_delta();
      t_unmapped();
      report_and_stop();
   end
   initial begin
      #100us;
      failures++;
      report_and_stop();
   end
endmodule
